/* File: hw/tap_pkg.sv */
// constants and carriers for the trip acknowledge and test position block
//
// How it works
// - node address is written from the panel only
// - locked panel refuses changes until password matches
// - any multifunction input may select test position
// - test position allows starts, no checkback trip
// - test position masks checkback and current protections
// - trips and warnings reach panel, bus, application
// - without autoreset a trip holds until acknowledged
// - acknowledge from panel, bus or multifunction input
// - with autoreset a trip clears once cause ends
package tap_pkg;

	localparam int NTRIP = 8;
	localparam int NEV   = 4;

	localparam logic [7:0] A_CTRL  = 8'h00;
	localparam logic [7:0] A_MFUNC = 8'h04;
	localparam logic [7:0] A_ACK   = 8'h08;
	localparam logic [7:0] A_STAT  = 8'h0C;
	localparam logic [7:0] A_NODE  = 8'h10;
	localparam logic [7:0] A_PWD   = 8'h14;
	localparam logic [7:0] A_ISTAT = 8'h18;
	localparam logic [7:0] A_IEN   = 8'h1C;
	localparam logic [7:0] A_ICLR  = 8'h20;

	localparam int CTRL_AUTO = 0;
	localparam int CTRL_LOCK = 1;

	localparam int ST_TRIP = 0;
	localparam int ST_WARN = 8;
	localparam int ST_TEST = 16;
	localparam int ST_UNLK = 17;

	localparam int EV_TRIP = 0;
	localparam int EV_CLR  = 1;
	localparam int EV_REF  = 2;
	localparam int EV_TEST = 3;

	localparam logic [1:0] CTRL_RST  = 2'h0;
	localparam logic [5:0] MFUNC_RST = 6'h00;
	localparam logic [7:0] NODE_RST  = 8'h00;
	localparam logic [7:0] PWD_RST   = 8'h00;

	// bit 7 is contactor checkback, bits 1..6 depend on motor current
	localparam int         TRIP_CB      = 7;
	localparam logic [7:0] CUR_DEP_MASK = 8'h7E;

	typedef enum logic [1:0] {
		MF_NONE = 2'h0,
		MF_TEST = 2'h1,
		MF_ACK  = 2'h2
	} tap_mf_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} tap_bus_t;

	typedef struct packed {
		logic       wr;
		logic       ack;
		logic [7:0] addr;
		logic [7:0] data;
	} tap_panel_t;

	// true when any input assigned to the given function is high
	function automatic logic mf_any(input logic [5:0] cfg,
		input logic [2:0] din, input tap_mf_t code);
		logic r;
		r = 1'b0;
		for (int k = 0; k < 3; k++) begin
			if (cfg[2*k +: 2] == code && din[k]) begin
				r = 1'b1;
			end
		end
		return r;
	endfunction

endpackage

/* File: hw/tap_sync3.sv */
// three stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module tap_sync3 (
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst_b,
	input  wire logic [2:0] i_pin,
	output logic      [2:0] o_level
);
	logic [2:0] s1_q, s2_q, s3_q, lvl_q;
	logic [2:0] lvl_d;

	// a change is taken only when the second and third stages agree
	always_comb begin
		lvl_d = lvl_q;
		for (int k = 0; k < 3; k++) begin
			if (s2_q[k] == s3_q[k]) begin
				lvl_d[k] = s3_q[k];
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s1_q  <= 3'h0;
			s2_q  <= 3'h0;
			s3_q  <= 3'h0;
			lvl_q <= 3'h0;
		end else begin
			s1_q  <= i_pin;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	assign o_level = lvl_q;
endmodule

/* File: hw/tap_top.sv */
// trip acknowledge, test position and panel configuration control
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module tap_top (
	input  wire logic                i_clk_sys,
	input  wire logic                i_rst_b,
	input  wire tap_pkg::tap_bus_t   i_bus,
	output logic              [31:0] o_rdata,
	input  wire tap_pkg::tap_panel_t i_pnl,
	input  wire logic                i_multifunction_input_zero,
	input  wire logic                i_multifunction_input_one,
	input  wire logic                i_multifunction_input_two,
	input  wire logic          [7:0] i_trip_cond,
	input  wire logic          [7:0] i_warn_cond,
	input  wire logic                i_checkback_missing,
	input  wire logic                i_start_req,
	output logic               [7:0] o_trip,
	output logic               [7:0] o_warn,
	output logic                     o_trip_any,
	output logic                     o_test_pos,
	output logic                     o_start_cmd,
	output logic               [7:0] o_node_addr,
	output logic                     o_irq
);
	import tap_pkg::*;

	logic [2:0]     mf_lvl;
	logic [7:0]     trip_w;
	logic           set_ev, clr_ev;

	logic [1:0]     ctrl_q, ctrl_d;
	logic [5:0]     mfunc_q, mfunc_d;
	logic [7:0]     node_q, node_d;
	logic [7:0]     pwd_q, pwd_d;
	logic           unlk_q, unlk_d;
	logic           refuse;
	logic           bus_wr_ctrl, pnl_ok;

	logic           test_q, test_d, test_now;
	logic           mfack_q, mfack_now, ack_now;
	logic [7:0]     cond_eff, mask;
	logic [7:0]     warn_q, warn_d;
	logic           any_q, any_d;
	logic           start_q, start_d;

	logic [NEV-1:0] istat_q, istat_d, ien_q, ien_d, ev;
	logic           irq_q, irq_d;
	logic [31:0]    rdata_q, rdata_d;

	tap_sync3 u_sync (
		.i_clk_sys (i_clk_sys),
		.i_rst_b   (i_rst_b),
		.i_pin     ({i_multifunction_input_two,
		             i_multifunction_input_one,
		             i_multifunction_input_zero}),
		.o_level   (mf_lvl)
	);

	// ---- configuration: bus and panel paths
	always_comb begin
		ctrl_d      = ctrl_q;
		mfunc_d     = mfunc_q;
		node_d      = node_q;
		pwd_d       = pwd_q;
		unlk_d      = unlk_q;
		refuse      = 1'b0;
		bus_wr_ctrl = i_bus.wr && i_bus.addr == A_CTRL;
		if (bus_wr_ctrl) begin
			ctrl_d = i_bus.wdata[1:0];
		end
		if (i_bus.wr && i_bus.addr == A_MFUNC) begin
			mfunc_d = i_bus.wdata[5:0];
		end
		if (i_bus.wr && i_bus.addr == A_PWD) begin
			pwd_d = i_bus.wdata[7:0];
		end
		// bus writes to the node address are dropped on purpose
		pnl_ok = !ctrl_q[CTRL_LOCK] || unlk_q;
		if (i_pnl.wr) begin
			if (i_pnl.addr == A_PWD) begin
				unlk_d = (i_pnl.data == pwd_q);
			end else if (!pnl_ok) begin
				refuse = 1'b1;
			end else if (i_pnl.addr == A_CTRL) begin
				ctrl_d = i_pnl.data[1:0];
			end else if (i_pnl.addr == A_MFUNC) begin
				mfunc_d = i_pnl.data[5:0];
			end else if (i_pnl.addr == A_NODE) begin
				node_d = i_pnl.data;
			end
		end
		if (!ctrl_d[CTRL_LOCK]) begin
			unlk_d = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctrl_q  <= CTRL_RST;
			mfunc_q <= MFUNC_RST;
			node_q  <= NODE_RST;
			pwd_q   <= PWD_RST;
			unlk_q  <= 1'b0;
		end else begin
			ctrl_q  <= ctrl_d;
			mfunc_q <= mfunc_d;
			node_q  <= node_d;
			pwd_q   <= pwd_d;
			unlk_q  <= unlk_d;
		end
	end

	// ---- test position, acknowledge sources and trip masking
	always_comb begin
		test_now  = mf_any(mfunc_q, mf_lvl, MF_TEST);
		test_d    = test_now;
		mfack_now = mf_any(mfunc_q, mf_lvl, MF_ACK);
		ack_now   = i_pnl.ack
		          | (i_bus.wr && i_bus.addr == A_ACK)
		          | (mfack_now & ~mfack_q);
		mask      = test_q ? CUR_DEP_MASK : 8'h00;
		cond_eff  = i_trip_cond;
		cond_eff[TRIP_CB] = i_checkback_missing;
		cond_eff  = cond_eff & ~mask;
		if (test_q) begin
			cond_eff[TRIP_CB] = 1'b0;
		end
		warn_d    = i_warn_cond & ~mask;
	end

	tap_trip_latch u_latch (
		.i_clk_sys (i_clk_sys),
		.i_rst_b   (i_rst_b),
		.i_cond    (cond_eff),
		.i_ack     (ack_now),
		.i_auto    (ctrl_q[CTRL_AUTO]),
		.o_trip    (trip_w),
		.o_set_ev  (set_ev),
		.o_clr_ev  (clr_ev)
	);

	// ---- start gating
	always_comb begin
		any_d   = |trip_w;
		start_d = i_start_req && (trip_w == 8'h00);
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			test_q  <= 1'b0;
			mfack_q <= 1'b0;
			warn_q  <= 8'h00;
			any_q   <= 1'b0;
			start_q <= 1'b0;
		end else begin
			test_q  <= test_d;
			mfack_q <= mfack_now;
			warn_q  <= warn_d;
			any_q   <= any_d;
			start_q <= start_d;
		end
	end

	// ---- interrupts and read data
	always_comb begin
		ev          = '0;
		ev[EV_TRIP] = set_ev;
		ev[EV_CLR]  = clr_ev;
		ev[EV_REF]  = refuse;
		ev[EV_TEST] = test_d ^ test_q;
		ien_d       = ien_q;
		istat_d     = istat_q;
		if (i_bus.wr && i_bus.addr == A_IEN) begin
			ien_d = i_bus.wdata[NEV-1:0];
		end
		if (i_bus.wr && i_bus.addr == A_ICLR) begin
			istat_d = istat_q & ~i_bus.wdata[NEV-1:0];
		end
		// a new event in the clearing cycle survives the clear
		istat_d = istat_d | ev;
		irq_d   = |(istat_d & ien_d);
		rdata_d = 32'h0000_0000;
		if (i_bus.rd) begin
			unique case (i_bus.addr)
			A_CTRL:  rdata_d[1:0] = ctrl_q;
			A_MFUNC: rdata_d[5:0] = mfunc_q;
			A_STAT: begin
				rdata_d[ST_TRIP +: 8] = trip_w;
				rdata_d[ST_WARN +: 8] = warn_q;
				rdata_d[ST_TEST]      = test_q;
				rdata_d[ST_UNLK]      = unlk_q;
			end
			A_NODE:  rdata_d[7:0] = node_q;
			A_ISTAT: rdata_d[NEV-1:0] = istat_q;
			A_IEN:   rdata_d[NEV-1:0] = ien_q;
			default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			istat_q <= '0;
			ien_q   <= '0;
			irq_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			istat_q <= istat_d;
			ien_q   <= ien_d;
			irq_q   <= irq_d;
			rdata_q <= rdata_d;
		end
	end

	assign o_rdata     = rdata_q;
	assign o_trip      = trip_w;
	assign o_warn      = warn_q;
	assign o_trip_any  = any_q;
	assign o_test_pos  = test_q;
	assign o_start_cmd = start_q;
	assign o_node_addr = node_q;
	assign o_irq       = irq_q;

	// ---- checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);

	node_path_a: assert property (
		i_bus.wr && i_bus.addr == A_NODE && !i_pnl.wr
		|=> $stable(o_node_addr))
		else $error("bus write changed node address");

	pnl_lock_a: assert property (
		ctrl_q[CTRL_LOCK] && !unlk_q && i_pnl.wr
		&& i_pnl.addr == A_NODE |=> $stable(o_node_addr))
		else $error("locked panel changed node address");

	test_sel_a: assert property (
		1 |=> o_test_pos == $past((mf_lvl & {
		mfunc_q[5:4] == MF_TEST, mfunc_q[3:2] == MF_TEST,
		mfunc_q[1:0] == MF_TEST}) != 3'h0))
		else $error("test position not following input");

	cb_test_a: assert property (
		o_test_pos && !o_trip[TRIP_CB] |=> !o_trip[TRIP_CB])
		else $error("checkback trip raised in test position");

	cur_mask_a: assert property (
		o_test_pos && ((o_trip & CUR_DEP_MASK) == 8'h00)
		|=> (o_trip & CUR_DEP_MASK) == 8'h00)
		else $error("current trip raised in test position");

	trip_hold_a: assert property (
		!ctrl_q[CTRL_AUTO] && !ack_now
		|=> ($past(o_trip) & ~o_trip) == 8'h00)
		else $error("trip released without acknowledge");

	ack_clear_a: assert property (
		ack_now |=> (o_trip & $past(o_trip & ~cond_eff)) == 8'h00)
		else $error("acknowledge did not release trip");

	auto_clr_a: assert property (
		ctrl_q[CTRL_AUTO] |=> (o_trip & ~$past(cond_eff)) == 8'h00)
		else $error("autoreset did not release trip");

	start_inh_a: assert property (
		o_trip != 8'h00 |=> !o_start_cmd)
		else $error("start passed while tripped");

	ack_keep_a: assert property (
		cond_eff != 8'h00
		|=> (o_trip & $past(cond_eff)) == $past(cond_eff))
		else $error("trip released while cause present");

	irq_level_a: assert property (
		o_irq == |(istat_q & ien_q))
		else $error("interrupt line not matching status");

	rdata_idle_a: assert property (
		!i_bus.rd |=> o_rdata == 32'h0000_0000)
		else $error("read data left standing");

	stat_read_a: assert property (
		i_bus.rd && i_bus.addr == A_STAT
		|=> o_rdata[ST_TRIP +: 8] == $past(o_trip))
		else $error("status read lost trip bits");

	trip_any_a: assert property (
		1 |=> o_trip_any == ($past(o_trip) != 8'h00))
		else $error("trip summary out of step");

	warn_mask_a: assert property (
		o_test_pos |=> (o_warn & CUR_DEP_MASK) == 8'h00)
		else $error("current warning shown in test position");

	refuse_flag_a: assert property (
		ctrl_q[CTRL_LOCK] && !unlk_q && i_pnl.wr
		&& i_pnl.addr != A_PWD |=> istat_q[EV_REF])
		else $error("refused panel write not flagged");

	node_set_a: assert property (
		i_pnl.wr && i_pnl.addr == A_NODE
		&& (!ctrl_q[CTRL_LOCK] || unlk_q)
		|=> o_node_addr == $past(i_pnl.data))
		else $error("panel did not set node address");

	start_pass_a: assert property (
		i_start_req && o_trip == 8'h00 |=> o_start_cmd)
		else $error("start refused while not tripped");
endmodule

/* File: hw/tap_trip_latch.sv */
// trip latches with acknowledge and autoreset release
`timescale 1ns/1ps
module tap_trip_latch (
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst_b,
	input  wire logic [7:0] i_cond,
	input  wire logic       i_ack,
	input  wire logic       i_auto,
	output logic      [7:0] o_trip,
	output logic            o_set_ev,
	output logic            o_clr_ev
);
	logic [7:0] trip_q, trip_d, rel;
	logic       set_q, set_d, clr_q, clr_d;

	always_comb begin
		// release only where the cause is gone; a live cause wins
		rel    = ~i_cond & {8{i_ack | i_auto}};
		trip_d = (trip_q & ~rel) | i_cond;
		set_d  = |(trip_d & ~trip_q);
		clr_d  = |(trip_q & ~trip_d);
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			trip_q <= 8'h00;
			set_q  <= 1'b0;
			clr_q  <= 1'b0;
		end else begin
			trip_q <= trip_d;
			set_q  <= set_d;
			clr_q  <= clr_d;
		end
	end

	assign o_trip   = trip_q;
	assign o_set_ev = set_q;
	assign o_clr_ev = clr_q;
endmodule

/* File: verif/tap_far.sv */
// far side model: operator panel and multifunction pins
`timescale 1ns/1ps
module tap_far (
	input  wire logic           i_clk_sys,
	output tap_pkg::tap_panel_t o_pnl,
	output logic          [2:0] o_pin
);
	import tap_pkg::*;
	initial begin
		o_pnl = '0;
		o_pin = 3'h0;
	end
	// panel strobes last exactly one cycle, like a key press event
	task automatic pwr(input logic [7:0] a, input logic [7:0] v);
		@(posedge i_clk_sys);
		o_pnl <= '{wr: 1'b1, ack: 1'b0, addr: a, data: v};
		@(posedge i_clk_sys);
		o_pnl <= '0;
	endtask
	task automatic pack();
		@(posedge i_clk_sys);
		o_pnl.ack <= 1'b1;
		@(posedge i_clk_sys);
		o_pnl.ack <= 1'b0;
	endtask
	task automatic pin(input int k, input logic v);
		@(posedge i_clk_sys);
		o_pin[k] <= v;
	endtask
endmodule

/* File: verif/tap_top_tb_top.sv */
// self-checking bench for the trip acknowledge block
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end
module tap_top_tb_top;
	import tap_pkg::*;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	tap_bus_t    b = '0;
	tap_panel_t  pnl;
	logic [2:0]  pin;
	logic [7:0]  tc = 8'h00;
	logic [7:0]  wc = 8'h00;
	logic        cb = 1'b0;
	logic        sr = 1'b0;
	logic [31:0] rdata;
	logic [31:0] d;
	logic [7:0]  trip;
	logic [7:0]  warn;
	logic [7:0]  node;
	logic        tany;
	logic        tpos;
	logic        scmd;
	logic        irq;
	int          error_cnt = 0;
	int          n_checks = 0;

	always #2.5 clk = ~clk;

	tap_far far (.i_clk_sys(clk), .o_pnl(pnl), .o_pin(pin));
	tap_top uut (
		.i_clk_sys(clk), .i_rst_b(rst_b), .i_bus(b), .o_rdata(rdata),
		.i_pnl(pnl), .i_multifunction_input_zero(pin[0]),
		.i_multifunction_input_one(pin[1]),
		.i_multifunction_input_two(pin[2]), .i_trip_cond(tc),
		.i_warn_cond(wc), .i_checkback_missing(cb), .i_start_req(sr),
		.o_trip(trip), .o_warn(warn), .o_trip_any(tany),
		.o_test_pos(tpos), .o_start_cmd(scmd), .o_node_addr(node),
		.o_irq(irq)
	);

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic bwr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		b <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge clk);
		b <= '0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic brd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		b <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge clk);
		b <= '0;
		@(negedge clk);
		v = rdata;
	endtask
	task automatic strt(input logic e);
		@(posedge clk);
		sr <= 1'b1;
		@(posedge clk);
		sr <= 1'b0;
		@(negedge clk);
		`CHK(scmd, e)
	endtask
	task automatic cond(input logic [7:0] t, input logic [7:0] w);
		@(posedge clk);
		tc <= t;
		wc <= w;
	endtask

	task automatic s_reg();
		brd(A_CTRL, d);
		`CHK(d, 32'h0)
		brd(8'h24, d);
		`CHK(d, 32'h0)
		`CHK(node, 8'h00)
	endtask
	task automatic s_cfg();
		far.pwr(A_NODE, 8'h5A);
		cyc(1);
		`CHK(node, 8'h5A)
		bwr(A_NODE, 32'h33);
		cyc(1);
		`CHK(node, 8'h5A)
		bwr(A_CTRL, 32'h2);
		far.pwr(A_NODE, 8'h11);
		cyc(1);
		`CHK(node, 8'h5A)
		brd(A_ISTAT, d);
		`CHK(d[EV_REF], 1'b1)
		far.pwr(A_PWD, 8'h3C);
		far.pwr(A_NODE, 8'h11);
		cyc(1);
		`CHK(node, 8'h5A)
		far.pwr(A_PWD, 8'h00);
		far.pwr(A_NODE, 8'h11);
		cyc(1);
		`CHK(node, 8'h11)
		brd(A_STAT, d);
		`CHK(d[ST_UNLK], 1'b1)
		far.pwr(A_CTRL, 8'h00);
		brd(A_CTRL, d);
		`CHK(d, 32'h0)
		bwr(A_ICLR, 32'hF);
		bwr(A_CTRL, 32'h0);
	endtask
	task automatic s_trip();
		bwr(A_IEN, 32'h1);
		cond(8'h04, 8'h81);
		cyc(3);
		`CHK(trip, 8'h04)
		`CHK(tany, 1'b1)
		`CHK(warn, 8'h81)
		`CHK(irq, 1'b1)
		strt(1'b0);
		bwr(A_ACK, 32'h1);
		cyc(1);
		`CHK(trip, 8'h04)
		cond(8'h00, 8'h81);
		cyc(3);
		`CHK(trip, 8'h04)
		brd(A_STAT, d);
		`CHK(d[15:0], 16'h8104)
		bwr(A_ICLR, 32'h1);
		cyc(1);
		`CHK(irq, 1'b0)
		far.pack();
		cyc(1);
		`CHK(trip, 8'h00)
		brd(A_ISTAT, d);
		`CHK(d[EV_CLR], 1'b1)
		strt(1'b1);
		cond(8'h01, 8'h00);
		cyc(3);
		`CHK(irq, 1'b1)
		bwr(A_IEN, 32'h0);
		cyc(1);
		`CHK(irq, 1'b0)
		cond(8'h00, 8'h00);
		bwr(A_ACK, 32'h1);
		cyc(1);
		`CHK(trip, 8'h00)
		bwr(A_ICLR, 32'hF);
	endtask
	task automatic s_auto();
		bwr(A_CTRL, 32'h1);
		cond(8'h10, 8'h00);
		cyc(3);
		`CHK(trip, 8'h10)
		cond(8'h00, 8'h00);
		cyc(2);
		`CHK(trip, 8'h00)
		bwr(A_CTRL, 32'h0);
	endtask
	// each input in turn, the others left unassigned
	task automatic s_test();
		for (int k = 0; k < 3; k++) begin
			bwr(A_MFUNC, 32'h1 << (2 * k));
			far.pin(k, 1'b1);
			cyc(6);
			`CHK(tpos, 1'b1)
			brd(A_STAT, d);
			`CHK(d[ST_TEST], 1'b1)
			@(posedge clk);
			cb <= 1'b1;
			cyc(3);
			`CHK(trip, 8'h00)
			strt(1'b1);
			cond(8'h0F, 8'h0F);
			cyc(3);
			`CHK(trip, 8'h01)
			`CHK(warn, 8'h01)
			cond(8'h00, 8'h00);
			bwr(A_ACK, 32'h1);
			far.pin(k, 1'b0);
			cyc(8);
			`CHK(tpos, 1'b0)
			`CHK(trip, 8'h80)
			@(posedge clk);
			cb <= 1'b0;
			bwr(A_ACK, 32'h1);
			cyc(1);
			`CHK(trip, 8'h00)
		end
	endtask
	task automatic s_mfack();
		bwr(A_MFUNC, 32'h20);
		cond(8'h02, 8'h00);
		cond(8'h00, 8'h00);
		cyc(2);
		`CHK(trip, 8'h02)
		far.pin(2, 1'b1);
		cyc(7);
		`CHK(trip, 8'h00)
		far.pin(2, 1'b0);
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		s_reg();
		s_cfg();
		s_trip();
		s_auto();
		s_test();
		s_mfack();
		report_and_stop();
	end
	// the tests need about 225 cycles; 4000 cycles, near eighteen times that, marks a hang
	initial begin
		#20000;
		error_cnt++;
		report_and_stop();
	end
endmodule
